//--- ivl_defines.svh
`ifndef IVL_DEFINES_SVH
`define IVL_DEFINES_SVH
`define IVL_SLOT_BYTES 20'h00004
`define IVL_FIX_UND 20'h0FFDC
`define IVL_FIX_OVF 20'h0FFE0
`define IVL_FIX_BRK 20'h0FFE4
`define IVL_FIX_BRK_PROBE 20'h0FFE6
`define IVL_FIX_AMATCH 20'h0FFE8
`define IVL_FIX_STEP 20'h0FFEC
`define IVL_FIX_SPECIAL 20'h0FFF0
`define IVL_FIX_ABREAK 20'h0FFF4
`define IVL_FIX_RESET 20'h0FFFC
`define IVL_BRK_RELOC_MARK 8'hFF
`define IVL_SWI_BRK 6'h00
`define IVL_SWI_SHARED_SER 6'h0F
`define IVL_SWI_SSU 6'h0F
`define IVL_SWI_IIC 6'h0F
`define IVL_RELOC_SPAN 20'h00100
`endif

//--- ivl_pkg.sv
package ivl_pkg;
  typedef enum logic [3:0] {
    IVL_SRC_UND, IVL_SRC_OVF, IVL_SRC_BRK, IVL_SRC_AMATCH, IVL_SRC_STEP,
    IVL_SRC_SPECIAL, IVL_SRC_ABREAK, IVL_SRC_RESET, IVL_SRC_SWI,
    IVL_SRC_PERIPH
  } ivl_src_t;
  typedef enum {IVL_IDLE, IVL_PROBE, IVL_FETCH, IVL_DONE} ivl_state_t;
endpackage : ivl_pkg

//--- ivl_vector_lookup.sv
`timescale 1ns/1ps
`include "ivl_defines.svh"
// Operation
// - each vector is four bytes long
// - acknowledged request not refused loads pc from vector
// - fixed table sits at 0FFDCh..0FFFFh
// - fixed slots in documented ascending order
// - four special sources share 0FFF0h slot
// - break byte FFh at 0FFE6h relocates
// - fixed high bytes feed id check
// - relocatable table spans 256 bytes
// - slot at base plus four times number
// - slot offset added to table base
// - break and software slots ignore enable
// - slot 15 shared, select bit picks owner
module ivl_vector_lookup
  import ivl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ack_valid,
  input wire ivl_src_t ack_src,
  input wire logic [5:0] ack_swi_num,
  input wire logic ack_ser_is_iic,
  input wire logic irq_enable,
  input wire logic [19:0] vector_table_base,
  input wire logic serial_unit_source_select,
  output logic busy,
  output logic mem_rd,
  output logic [19:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic pc_load,
  output logic [19:0] pc_value,
  output logic id_byte_valid,
  output logic [7:0] id_byte,
  output logic ack_refused
);
  // ---------------------------------------------------------------
  // slot address selection
  // ---------------------------------------------------------------
  logic [19:0] fix_addr;
  logic sel_reloc;
  logic swi_reserved;
  logic ser_mismatch;
  logic refuse;
  always_comb
  begin
    fix_addr = `IVL_FIX_RESET;
    sel_reloc = 1'b0;
    case (ack_src)
      IVL_SRC_UND: fix_addr = `IVL_FIX_UND;
      IVL_SRC_OVF: fix_addr = `IVL_FIX_OVF;
      IVL_SRC_BRK: fix_addr = `IVL_FIX_BRK;
      IVL_SRC_AMATCH: fix_addr = `IVL_FIX_AMATCH;
      IVL_SRC_STEP: fix_addr = `IVL_FIX_STEP;
      IVL_SRC_SPECIAL: fix_addr = `IVL_FIX_SPECIAL;
      IVL_SRC_ABREAK: fix_addr = `IVL_FIX_ABREAK;
      IVL_SRC_RESET: fix_addr = `IVL_FIX_RESET;
      IVL_SRC_SWI: sel_reloc = 1'b1;
      IVL_SRC_PERIPH: sel_reloc = 1'b1;
      default: fix_addr = `IVL_FIX_RESET;
    endcase
  end
  // reserved numbers 2..6, 16, 23, 27, 28, 31, 42..49, 52..55
  always_comb
  begin
    swi_reserved = (ack_swi_num >= 6'd2 && ack_swi_num <= 6'd6)
      || ack_swi_num == 6'd16 || ack_swi_num == 6'd23
      || ack_swi_num == 6'd27 || ack_swi_num == 6'd28
      || ack_swi_num == 6'd31
      || (ack_swi_num >= 6'd42 && ack_swi_num <= 6'd49)
      || (ack_swi_num >= 6'd52 && ack_swi_num <= 6'd55);
    ser_mismatch = ack_swi_num == `IVL_SWI_SHARED_SER
      && ack_ser_is_iic != serial_unit_source_select;
    // peripherals need enable and a live slot; break/swi do not
    refuse = ack_src == IVL_SRC_PERIPH
      && (swi_reserved || ser_mismatch || !irq_enable);
  end
  // ---------------------------------------------------------------
  // fetch sequencer
  // ---------------------------------------------------------------
  ivl_state_t st_r, st_nxt;
  logic [19:0] addr_r, addr_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic [19:0] acc_r, acc_nxt;
  logic fixed_r, fixed_nxt;
  logic [19:0] pc_r, pc_nxt;
  logic pcl_r, pcl_nxt;
  logic [7:0] idb_r, idb_nxt;
  logic idv_r, idv_nxt;
  logic ref_r, ref_nxt;
  always_comb
  begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    idx_nxt = idx_r;
    acc_nxt = acc_r;
    fixed_nxt = fixed_r;
    pc_nxt = pc_r;
    pcl_nxt = 1'b0;
    idb_nxt = idb_r;
    idv_nxt = 1'b0;
    ref_nxt = 1'b0;
    case (st_r)
      IVL_IDLE:
      begin
        if (ack_valid && refuse)
          ref_nxt = 1'b1;
        else if (ack_valid)
        begin
          idx_nxt = 2'd0;
          acc_nxt = 20'h00000;
          fixed_nxt = !sel_reloc;
          if (sel_reloc)
            addr_nxt = vector_table_base
              + {12'h000, ack_swi_num, 2'b00};
          else
            addr_nxt = fix_addr;
          if (ack_src == IVL_SRC_BRK)
            st_nxt = IVL_PROBE;
          else
            st_nxt = IVL_FETCH;
        end
      end
      IVL_PROBE:
      begin
        // mark byte read decides fixed vs relocated break vector
        if (mem_rdata == `IVL_BRK_RELOC_MARK)
        begin
          addr_nxt = vector_table_base
            + {12'h000, `IVL_SWI_BRK, 2'b00};
          fixed_nxt = 1'b0;
        end
        st_nxt = IVL_FETCH;
      end
      IVL_FETCH:
      begin
        acc_nxt = acc_r;
        case (idx_r)
          2'd0: acc_nxt[7:0] = mem_rdata;
          2'd1: acc_nxt[15:8] = mem_rdata;
          2'd2: acc_nxt[19:16] = mem_rdata[3:0];
          default: acc_nxt = acc_r;
        endcase
        if (idx_r == 2'd3)
        begin
          idb_nxt = mem_rdata;
          idv_nxt = fixed_r;
          st_nxt = IVL_DONE;
        end
        idx_nxt = 2'(idx_r + 2'd1);
      end
      IVL_DONE:
      begin
        pc_nxt = acc_r;
        pcl_nxt = 1'b1;
        st_nxt = IVL_IDLE;
      end
      default: st_nxt = IVL_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= IVL_IDLE;
      addr_r <= 20'h00000;
      idx_r <= 2'd0;
      acc_r <= 20'h00000;
      fixed_r <= 1'b0;
      pc_r <= 20'h00000;
      pcl_r <= 1'b0;
      idb_r <= 8'h00;
      idv_r <= 1'b0;
      ref_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      idx_r <= idx_nxt;
      acc_r <= acc_nxt;
      fixed_r <= fixed_nxt;
      pc_r <= pc_nxt;
      pcl_r <= pcl_nxt;
      idb_r <= idb_nxt;
      idv_r <= idv_nxt;
      ref_r <= ref_nxt;
    end
  end
  // ---------------------------------------------------------------
  // outputs; memory is combinational read, data same cycle
  // ---------------------------------------------------------------
  assign busy = st_r != IVL_IDLE;
  assign mem_rd = st_r == IVL_PROBE || st_r == IVL_FETCH;
  assign mem_addr = st_r == IVL_PROBE ? `IVL_FIX_BRK_PROBE
    : 20'(addr_r + {18'h00000, idx_r});
  assign pc_load = pcl_r;
  assign pc_value = pc_r;
  assign id_byte = idb_r;
  assign id_byte_valid = idv_r;
  assign ack_refused = ref_r;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_RESET_SLOT: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    ack_valid && !busy && ack_src == IVL_SRC_RESET |=> mem_addr == 20'h0FFFC)
    else $error("reset vector slot wrong");
  AST_SPECIAL_SLOT: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    ack_valid && !busy && ack_src == IVL_SRC_SPECIAL
    |=> mem_addr == 20'h0FFF0)
    else $error("special vector slot wrong");
  AST_BRK_PROBE: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    ack_valid && !busy && ack_src == IVL_SRC_BRK
    |=> mem_rd && mem_addr == 20'h0FFE6)
    else $error("break probe address wrong");
  AST_RELOC_ADDR: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    ack_valid && !busy && ack_src == IVL_SRC_SWI
    |=> mem_addr
      == 20'($past(vector_table_base) + {$past(ack_swi_num), 2'b00}))
    else $error("relocatable slot address wrong");
  AST_FETCH_LEN: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    ack_valid && !busy && ack_src == IVL_SRC_UND |=> mem_rd [*4] ##1 !mem_rd)
    else $error("vector fetch not four bytes");
  AST_BYTE_ORDER: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    st_r == IVL_FETCH && idx_r != 2'd3
    |=> mem_addr == 20'($past(mem_addr) + 20'h00001))
    else $error("vector bytes not ascending");
  AST_PC_LOAD: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    ack_valid && !busy && ack_src == IVL_SRC_OVF |=> ##5 pc_load)
    else $error("pc not loaded after fetch");
  AST_RESERVED: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    ack_valid && !busy && ack_src == IVL_SRC_PERIPH && ack_swi_num == 6'd16
    |=> ack_refused && !busy)
    else $error("reserved slot selected");
  AST_SWI_NOMASK: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    ack_valid && !busy && ack_src == IVL_SRC_SWI && !irq_enable |=> busy)
    else $error("software slot masked");
  AST_ID_BYTE: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    id_byte_valid |-> $past(mem_addr[1:0]) == 2'b11
      && $past(mem_addr[19:8]) == 12'h0FF)
    else $error("id byte not fixed high byte");
endmodule : ivl_vector_lookup

//--- ivl_mem_model.sv
`timescale 1ns/1ps
module ivl_mem_model
(
  input wire logic mem_rd,
  input wire logic [19:0] mem_addr,
  input wire logic brk_reloc,
  output logic [7:0] mem_rdata
);
  // ----------------------------------------
  // vector memory, asynchronous read
  // ----------------------------------------
  logic [7:0] last_r = 8'h00;
  // released bus shows inverse of last byte, never a stale value
  always @(mem_rd or mem_addr or brk_reloc)
  begin
    if (mem_rd)
    begin
      if (brk_reloc && mem_addr == 20'h0FFE6)
        mem_rdata = 8'hFF;
      else
        mem_rdata = mem_addr[7:0] ^ 8'h3C;
      last_r = mem_rdata;
    end
    else
      mem_rdata = ~last_r;
  end
endmodule : ivl_mem_model

//--- interrupt_vector_lookup_tb.sv
`timescale 1ns/1ps
module interrupt_vector_lookup_tb;
  import ivl_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ack_valid = 1'b0;
  ivl_src_t ack_src = IVL_SRC_UND;
  logic [5:0] ack_swi_num = 6'h00;
  logic ack_ser_is_iic = 1'b0;
  logic irq_enable = 1'b0;
  logic [19:0] base = 20'h0C400;
  logic sel = 1'b0;
  logic brk_reloc = 1'b0;
  logic busy, mem_rd, pc_load, id_byte_valid, ack_refused;
  logic [19:0] mem_addr, pc_value;
  logic [7:0] mem_rdata, id_byte;
  int mismatches = 0;
  int checked = 0;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [19:0] e,
    input logic [19:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  function automatic logic [7:0] bt(input logic [19:0] a);
    bt = a[7:0] ^ 8'h3C;
  endfunction : bt
  // one acknowledge; a is the slot address, r set when refusal expected
  task automatic req(input ivl_src_t s, input logic [5:0] n,
    input logic iic, input logic [19:0] a, input logic r);
    int k;
    int nb;
    logic idv;
    logic [7:0] b2;
    logic [19:0] lat;
    k = 0;
    nb = 0;
    idv = 1'b0;
    b2 = bt(a + 20'h2);
    lat = r ? 20'h0 : (s == IVL_SRC_BRK) ? 20'h6 : 20'h5;
    ack_src = s;
    ack_swi_num = n;
    ack_ser_is_iic = iic;
    ack_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    ack_valid = 1'b0;
    while (k < 12 && pc_load !== 1'b1 && ack_refused !== 1'b1)
    begin
      if (busy === 1'b1)
        nb++;
      if (id_byte_valid === 1'b1)
        idv = 1'b1;
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (k == 12)
    begin
      mismatches++;
      $display("[ERR] response expected in 12 cycles seen %0d", k);
      wrap_up();
    end
    chk("refused", {19'h0, r}, {19'h0, ack_refused});
    chk("latency", lat, 20'(k));
    chk("busy", lat, 20'(nb));
    chk("id_valid", {19'h0, !r && a >= 20'h0FFDC}, {19'h0, idv});
    if (!r)
    begin
      chk("pc", {b2[3:0], bt(a + 20'h1), bt(a)}, pc_value);
      if (a >= 20'h0FFDC)
        chk("id", {12'h0, bt(a + 20'h3)}, {12'h0, id_byte});
    end
    // one idle edge so ack_valid is never lowered and raised in one step
    @(posedge sys_clk);
    #1;
  endtask : req
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // step and address break left alone: tool-only sources
  task automatic t_fixed();
    req(IVL_SRC_UND, 6'h00, 1'b0, 20'h0FFDC, 1'b0);
    req(IVL_SRC_OVF, 6'h00, 1'b0, 20'h0FFE0, 1'b0);
    req(IVL_SRC_AMATCH, 6'h00, 1'b0, 20'h0FFE8, 1'b0);
    req(IVL_SRC_SPECIAL, 6'h00, 1'b0, 20'h0FFF0, 1'b0);
    req(IVL_SRC_RESET, 6'h00, 1'b0, 20'h0FFFC, 1'b0);
  endtask : t_fixed
  task automatic t_brk();
    req(IVL_SRC_BRK, 6'h00, 1'b0, 20'h0FFE4, 1'b0);
    brk_reloc = 1'b1;
    req(IVL_SRC_BRK, 6'h00, 1'b0, base, 1'b0);
    brk_reloc = 1'b0;
  endtask : t_brk
  task automatic t_swi();
    irq_enable = 1'b0;
    req(IVL_SRC_SWI, 6'h00, 1'b0, base, 1'b0);
    req(IVL_SRC_SWI, 6'h07, 1'b0, base + 20'h1C, 1'b0);
    req(IVL_SRC_SWI, 6'h11, 1'b0, base + 20'h44, 1'b0);
    req(IVL_SRC_SWI, 6'h3F, 1'b0, base + 20'hFC, 1'b0);
  endtask : t_swi
  task automatic t_periph();
    irq_enable = 1'b1;
    req(IVL_SRC_PERIPH, 6'h01, 1'b0, base + 20'h4, 1'b0);
    req(IVL_SRC_PERIPH, 6'h02, 1'b0, base, 1'b1);
    req(IVL_SRC_PERIPH, 6'h10, 1'b0, base, 1'b1);
    sel = 1'b1;
    req(IVL_SRC_PERIPH, 6'h0F, 1'b1, base + 20'h3C, 1'b0);
    req(IVL_SRC_PERIPH, 6'h0F, 1'b0, base, 1'b1);
    irq_enable = 1'b0;
    req(IVL_SRC_PERIPH, 6'h07, 1'b0, base, 1'b1);
  endtask : t_periph
  // ----------------------------------------
  // harness
  // ----------------------------------------
  ivl_vector_lookup i_dut (.sys_clk(sys_clk), .rstn(rstn),
    .ack_valid(ack_valid), .ack_src(ack_src), .ack_swi_num(ack_swi_num),
    .ack_ser_is_iic(ack_ser_is_iic), .irq_enable(irq_enable),
    .vector_table_base(base), .serial_unit_source_select(sel),
    .busy(busy), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .pc_load(pc_load), .pc_value(pc_value),
    .id_byte_valid(id_byte_valid), .id_byte(id_byte),
    .ack_refused(ack_refused));
  ivl_mem_model i_mem (.mem_rd(mem_rd), .mem_addr(mem_addr),
    .brk_reloc(brk_reloc), .mem_rdata(mem_rdata));
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    t_fixed();
    t_brk();
    t_swi();
    t_periph();
    wrap_up();
  end
endmodule : interrupt_vector_lookup_tb
